//--- common/sha_pkg.sv
// shared constants, types and tables of the hash accelerator
package sha_pkg;
    typedef enum logic [1:0] {ALG_SHA1, ALG_SHA256, ALG_SHA384, ALG_SHA512} alg_t;
    typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_ROUND, ST_ADD, ST_DIGEST} state_t;

    localparam int         TEXT_WORDS = 32;
    localparam logic [7:0] TEXT_LIMIT = 8'h80;
    localparam logic [1:0] CTRL_SEL   = 2'h2;
    localparam logic [3:0] OFS_FIRST  = 4'h0;
    localparam logic [3:0] OFS_NEXT   = 4'h4;
    localparam logic [3:0] OFS_LOAD   = 4'h8;
    localparam logic [3:0] OFS_BUSY   = 4'hc;

    localparam logic [6:0] LAST_ROUND_64 = 7'h3f;
    localparam logic [6:0] LAST_ROUND_80 = 7'h4f;
    localparam logic [6:0] SHA1_PHASE_1  = 7'h14;
    localparam logic [6:0] SHA1_PHASE_2  = 7'h28;
    localparam logic [6:0] SHA1_PHASE_3  = 7'h3c;
    localparam logic [2:0] LOAD_LAST     = 3'h7;

    localparam logic [7:0] BLOCK_MIN  = 8'h3c;
    localparam logic [7:0] BLOCK_MAX  = 8'h64;
    localparam logic [7:0] DIGEST_MIN = 8'h08;
    localparam logic [7:0] DIGEST_MAX = 8'h14;

    localparam logic [0:3][4:0] DIGEST_WORDS = {5'h05, 5'h08, 5'h0c, 5'h10};

    localparam logic [0:3][31:0] SHA1_K = {32'h5a827999, 32'h6ed9eba1, 32'h8f1bbcdc, 32'hca62c1d6};

    localparam logic [0:7][31:0] SHA1_IV = {32'h67452301, 32'hefcdab89, 32'h98badcfe, 32'h10325476,
                                            32'hc3d2e1f0, 32'h0, 32'h0, 32'h0};

    localparam logic [0:7][63:0] IV512 = {
        64'h6a09e667f3bcc908, 64'hbb67ae8584caa73b, 64'h3c6ef372fe94f82b, 64'ha54ff53a5f1d36f1,
        64'h510e527fade682d1, 64'h9b05688c2b3e6c1f, 64'h1f83d9abfb41bd6b, 64'h5be0cd19137e2179};

    localparam logic [0:7][63:0] IV384 = {
        64'hcbbb9d5dc1059ed8, 64'h629a292a367cd507, 64'h9159015a3070dd17, 64'h152fecd8f70e5939,
        64'h67332667ffc00b31, 64'h8eb44a8768581511, 64'hdb0c2e0d64f98fa7, 64'h47b5481dbefa4fa4};

    // round constants; the upper halves of the first 64 serve the 32-bit variant
    localparam logic [0:79][63:0] K_TAB = {
        64'h428a2f98d728ae22, 64'h7137449123ef65cd, 64'hb5c0fbcfec4d3b2f, 64'he9b5dba58189dbbc,
        64'h3956c25bf348b538, 64'h59f111f1b605d019, 64'h923f82a4af194f9b, 64'hab1c5ed5da6d8118,
        64'hd807aa98a3030242, 64'h12835b0145706fbe, 64'h243185be4ee4b28c, 64'h550c7dc3d5ffb4e2,
        64'h72be5d74f27b896f, 64'h80deb1fe3b1696b1, 64'h9bdc06a725c71235, 64'hc19bf174cf692694,
        64'he49b69c19ef14ad2, 64'hefbe4786384f25e3, 64'h0fc19dc68b8cd5b5, 64'h240ca1cc77ac9c65,
        64'h2de92c6f592b0275, 64'h4a7484aa6ea6e483, 64'h5cb0a9dcbd41fbd4, 64'h76f988da831153b5,
        64'h983e5152ee66dfab, 64'ha831c66d2db43210, 64'hb00327c898fb213f, 64'hbf597fc7beef0ee4,
        64'hc6e00bf33da88fc2, 64'hd5a79147930aa725, 64'h06ca6351e003826f, 64'h142929670a0e6e70,
        64'h27b70a8546d22ffc, 64'h2e1b21385c26c926, 64'h4d2c6dfc5ac42aed, 64'h53380d139d95b3df,
        64'h650a73548baf63de, 64'h766a0abb3c77b2a8, 64'h81c2c92e47edaee6, 64'h92722c851482353b,
        64'ha2bfe8a14cf10364, 64'ha81a664bbc423001, 64'hc24b8b70d0f89791, 64'hc76c51a30654be30,
        64'hd192e819d6ef5218, 64'hd69906245565a910, 64'hf40e35855771202a, 64'h106aa07032bbd1b8,
        64'h19a4c116b8d2d0c8, 64'h1e376c085141ab53, 64'h2748774cdf8eeb99, 64'h34b0bcb5e19b48a8,
        64'h391c0cb3c5c95a63, 64'h4ed8aa4ae3418acb, 64'h5b9cca4f7763e373, 64'h682e6ff3d6b2b8a3,
        64'h748f82ee5defb2fc, 64'h78a5636f43172f60, 64'h84c87814a1f0ab72, 64'h8cc702081a6439ec,
        64'h90befffa23631e28, 64'ha4506cebde82bde9, 64'hbef9a3f7b2c67915, 64'hc67178f2e372532b,
        64'hca273eceea26619c, 64'hd186b8c721c0c207, 64'heada7dd6cde0eb1e, 64'hf57d4f7fee6ed178,
        64'h06f067aa72176fba, 64'h0a637dc5a2c898a6, 64'h113f9804bef90dae, 64'h1b710b35131c471b,
        64'h28db77f523047d84, 64'h32caab7b40c72493, 64'h3c9ebe0a15c9bebc, 64'h431d67c49c100d4c,
        64'h4cc5d4becb3e42b6, 64'h597f299cfc657e2a, 64'h5fcb6fab3ad6faec, 64'h6c44198c4a475817};
endpackage

//--- hdl/sha_hash_accelerator.sv
// avalon slave, text words, control sequencer and hash state of the accelerator
`timescale 1ns/1ps
module sha_hash_accelerator (
    input  logic        clk,
    input  logic        nrst,
    input  logic [7:0]  avs_address,
    input  logic        avs_read,
    input  logic        avs_write,
    input  logic [31:0] avs_writedata,
    input  logic [3:0]  avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic        avs_waitrequest
);
    sha_pkg::state_t   state_reg;
    sha_pkg::alg_t     alg_reg;
    sha_pkg::alg_t     sel_alg;
    logic              first_reg;
    logic [6:0]        round_reg;
    logic [6:0]        last_round;
    logic [2:0]        load_cnt_reg;
    logic [3:0]        busy_reg;
    logic [7:0][63:0]  hash_reg;
    logic [7:0][63:0]  work_reg;
    logic [7:0][63:0]  iv;
    logic [7:0][63:0]  st_next;
    logic [15:0][63:0] win_reg;
    logic [63:0]       w_new;
    logic [63:0]       k_word;
    logic [31:0]       text_reg [sha_pkg::TEXT_WORDS];
    logic [31:0]       rd_next;
    logic [3:0]        ofs;
    logic              wide;
    logic              take_wr;
    logic              is_text;
    logic              is_ctrl;
    logic              is_trig_ofs;
    logic              trig;
    logic              trig_load;
    logic              trig_first;
    logic              idle;
    logic              wb_en;
    logic [7:0]        op_cnt_reg;

    // bus decode

    assign take_wr     = avs_write && !avs_waitrequest;
    assign is_text     = avs_address < sha_pkg::TEXT_LIMIT;
    assign is_ctrl     = avs_address[7:6] == sha_pkg::CTRL_SEL;
    assign ofs         = avs_address[3:0];
    assign sel_alg     = sha_pkg::alg_t'(avs_address[5:4]);
    assign idle        = state_reg == sha_pkg::ST_IDLE;
    assign trig_first  = ofs == sha_pkg::OFS_FIRST;
    assign trig_load   = ofs == sha_pkg::OFS_LOAD;
    assign is_trig_ofs = trig_first || trig_load || ofs == sha_pkg::OFS_NEXT;
    // a trigger is taken only while every algorithm is idle
    assign trig = take_wr && is_ctrl && is_trig_ofs && idle
               && avs_byteenable[0] && avs_writedata[0];

    always_comb begin
        rd_next = 32'h0;
        if (is_text) begin
            rd_next = text_reg[avs_address[6:2]];
        end else if (is_ctrl && ofs == sha_pkg::OFS_BUSY) begin
            rd_next = {31'h0, busy_reg[sel_alg]};
        end
    end

    // one wait cycle, then a single low cycle in which the master completes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_next;
        end
    end

    // algorithm dependent selections

    assign wide       = alg_reg == sha_pkg::ALG_SHA384 || alg_reg == sha_pkg::ALG_SHA512;
    assign last_round = alg_reg == sha_pkg::ALG_SHA256 ? sha_pkg::LAST_ROUND_64 : sha_pkg::LAST_ROUND_80;
    assign k_word     = alg_reg == sha_pkg::ALG_SHA256 ? {32'h0, sha_pkg::K_TAB[round_reg][63:32]}
                                                       : sha_pkg::K_TAB[round_reg];
    assign wb_en      = state_reg == sha_pkg::ST_DIGEST && load_cnt_reg == sha_pkg::LOAD_LAST;

    always_comb begin
        iv = '0;
        for (int i = 0; i < 8; i++) begin
            case (alg_reg)
                sha_pkg::ALG_SHA1: begin
                    iv[i] = {32'h0, sha_pkg::SHA1_IV[i]};
                end
                sha_pkg::ALG_SHA256: begin
                    iv[i] = {32'h0, sha_pkg::IV512[i][63:32]};
                end
                sha_pkg::ALG_SHA384: begin
                    iv[i] = sha_pkg::IV384[i];
                end
                default: begin
                    iv[i] = sha_pkg::IV512[i];
                end
            endcase
        end
    end

    // sequencer: prepare, rounds, add for a block; fixed wait for a digest load

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= sha_pkg::ST_IDLE;
            alg_reg      <= sha_pkg::ALG_SHA1;
            first_reg    <= 1'b0;
            round_reg    <= 7'h0;
            load_cnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                sha_pkg::ST_IDLE: begin
                    if (trig) begin
                        alg_reg      <= sel_alg;
                        first_reg    <= trig_first;
                        round_reg    <= 7'h0;
                        load_cnt_reg <= 3'h0;
                        state_reg    <= trig_load ? sha_pkg::ST_DIGEST : sha_pkg::ST_PREP;
                    end
                end
                sha_pkg::ST_PREP: begin
                    state_reg <= sha_pkg::ST_ROUND;
                end
                sha_pkg::ST_ROUND: begin
                    if (round_reg == last_round) begin
                        state_reg <= sha_pkg::ST_ADD;
                    end else begin
                        round_reg <= round_reg + 7'h1;
                    end
                end
                sha_pkg::ST_ADD: begin
                    state_reg <= sha_pkg::ST_IDLE;
                end
                sha_pkg::ST_DIGEST: begin
                    if (load_cnt_reg == sha_pkg::LOAD_LAST) begin
                        state_reg <= sha_pkg::ST_IDLE;
                    end else begin
                        load_cnt_reg <= load_cnt_reg + 3'h1;
                    end
                end
                default: begin
                    state_reg <= sha_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 4'h0;
        end else if (trig) begin
            busy_reg[sel_alg] <= 1'b1;
        end else if (state_reg == sha_pkg::ST_ADD || wb_en) begin
            busy_reg <= 4'h0;
        end
    end

    // working variables and message schedule window

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            work_reg <= '0;
            win_reg  <= '0;
        end else if (state_reg == sha_pkg::ST_PREP) begin
            work_reg <= first_reg ? iv : hash_reg;
            for (int i = 0; i < 16; i++) begin
                if (wide) begin
                    win_reg[i] <= {text_reg[2 * i], text_reg[2 * i + 1]};
                end else begin
                    win_reg[i] <= {32'h0, text_reg[i]};
                end
            end
        end else if (state_reg == sha_pkg::ST_ROUND) begin
            work_reg <= st_next;
            win_reg  <= {w_new, win_reg[15:1]};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hash_reg <= '0;
        end else if (state_reg == sha_pkg::ST_PREP && first_reg) begin
            hash_reg <= iv;
        end else if (state_reg == sha_pkg::ST_ADD) begin
            for (int i = 0; i < 8; i++) begin
                if (wide) begin
                    hash_reg[i] <= hash_reg[i] + work_reg[i];
                end else begin
                    hash_reg[i] <= {32'h0, hash_reg[i][31:0] + work_reg[i][31:0]};
                end
            end
        end
    end

    sha_round u_round (
        .alg     (alg_reg),
        .round   (round_reg),
        .st      (work_reg),
        .win     (win_reg),
        .k       (k_word),
        .st_next (st_next),
        .w_new   (w_new)
    );

    // text words: written by software while idle, overwritten by the digest

    generate
        for (genvar j = 0; j < sha_pkg::TEXT_WORDS; j++) begin : g_text
            logic [31:0] dig_word;
            logic        hit;
            assign dig_word = wide ? ((j % 2 == 1) ? hash_reg[(j / 2) % 8][31:0] : hash_reg[(j / 2) % 8][63:32])
                                   : hash_reg[j % 8][31:0];
            assign hit = take_wr && idle && is_text && avs_address[6:2] == 5'(j);
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    text_reg[j] <= 32'h0;
                end else if (wb_en && 5'(j) < sha_pkg::DIGEST_WORDS[alg_reg]) begin
                    text_reg[j] <= dig_word;
                end else if (hit) begin
                    for (int b = 0; b < 4; b++) begin
                        if (avs_byteenable[b]) begin
                            text_reg[j][8 * b +: 8] <= avs_writedata[8 * b +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    // checks

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_cnt_reg <= 8'h0;
        end else if (trig) begin
            op_cnt_reg <= 8'h0;
        end else if (!idle && op_cnt_reg != 8'hff) begin
            op_cnt_reg <= op_cnt_reg + 8'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    busy_rise_a: assert property (trig |=> busy_reg[$past(sel_alg)] && !idle)
        else $error("busy flag did not rise after a trigger");

    busy_one_a: assert property ($onehot0(busy_reg) && ((busy_reg != 4'h0) == !idle))
        else $error("busy flags disagree with the sequencer");

    block_time_a: assert property (state_reg == sha_pkg::ST_ADD |->
        op_cnt_reg + 8'h1 >= sha_pkg::BLOCK_MIN && op_cnt_reg + 8'h1 <= sha_pkg::BLOCK_MAX)
        else $error("block time out of range");

    digest_time_a: assert property (wb_en |->
        op_cnt_reg + 8'h1 >= sha_pkg::DIGEST_MIN && op_cnt_reg + 8'h1 <= sha_pkg::DIGEST_MAX)
        else $error("digest time out of range");

    first_iv_a: assert property (state_reg == sha_pkg::ST_PREP && first_reg |=>
        work_reg == $past(iv) && hash_reg == $past(iv))
        else $error("first block did not start from initial values");

    next_chain_a: assert property (state_reg == sha_pkg::ST_PREP && !first_reg |=>
        work_reg == $past(hash_reg))
        else $error("next block did not continue from stored state");

    digest_word0_a: assert property (wb_en |=>
        text_reg[0] == ($past(wide) ? $past(hash_reg[0][63:32]) : $past(hash_reg[0][31:0])))
        else $error("leftmost digest word not in word 0");

    sha1_tail_a: assert property (wb_en && alg_reg == sha_pkg::ALG_SHA1 |=>
        text_reg[5] == $past(text_reg[5]) && text_reg[4] == $past(hash_reg[4][31:0]))
        else $error("sha-1 digest placement wrong");

    sha384_tail_a: assert property (wb_en && alg_reg == sha_pkg::ALG_SHA384 |=>
        text_reg[12] == $past(text_reg[12]) && text_reg[11] == $past(hash_reg[5][31:0]))
        else $error("sha-384 digest placement wrong");

    text_quiet_a: assert property (!idle && !wb_en |=> text_reg[0] == $past(text_reg[0]))
        else $error("text word changed during an operation");

    round_end_a: assert property (state_reg == sha_pkg::ST_ROUND && round_reg == last_round |=>
        state_reg == sha_pkg::ST_ADD ##1 idle && busy_reg == 4'h0)
        else $error("block did not finish after its last round");

    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    sha1_block_c: cover property (state_reg == sha_pkg::ST_ADD && alg_reg == sha_pkg::ALG_SHA1 && first_reg);
    next_block_c: cover property (state_reg == sha_pkg::ST_ADD && alg_reg == sha_pkg::ALG_SHA256 && !first_reg);
    sha512_dig_c: cover property (wb_en && alg_reg == sha_pkg::ALG_SHA512);
    sha384_dig_c: cover property (wb_en && alg_reg == sha_pkg::ALG_SHA384);
endmodule

//--- hdl/sha_round.sv
// one compression round and one schedule step for all four algorithms
`timescale 1ns/1ps
module sha_round (
    input  sha_pkg::alg_t     alg,
    input  logic [6:0]        round,
    input  logic [7:0][63:0]  st,
    input  logic [15:0][63:0] win,
    input  logic [63:0]       k,
    output logic [7:0][63:0]  st_next,
    output logic [63:0]       w_new
);
    function automatic logic [31:0] ror32(input logic [31:0] x, input int n);
        return (x >> n) | (x << (32 - n));
    endfunction

    function automatic logic [63:0] ror64(input logic [63:0] x, input int n);
        return (x >> n) | (x << (64 - n));
    endfunction

    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] t1;
    logic [31:0] t2;
    logic [31:0] fk;
    logic [63:0] u1;
    logic [63:0] u2;

    assign a = st[0][31:0];
    assign b = st[1][31:0];
    assign c = st[2][31:0];
    assign d = st[3][31:0];
    assign e = st[4][31:0];

    always_comb begin
        st_next = st;
        w_new   = 64'h0;
        t1      = 32'h0;
        t2      = 32'h0;
        fk      = 32'h0;
        u1      = 64'h0;
        u2      = 64'h0;
        for (int i = 1; i < 8; i++) begin
            st_next[i] = st[i - 1];
        end
        case (alg)
            sha_pkg::ALG_SHA1: begin
                if (round < sha_pkg::SHA1_PHASE_1) begin
                    fk = ((b & c) | (~b & d)) + sha_pkg::SHA1_K[0];
                end else if (round < sha_pkg::SHA1_PHASE_2) begin
                    fk = (b ^ c ^ d) + sha_pkg::SHA1_K[1];
                end else if (round < sha_pkg::SHA1_PHASE_3) begin
                    fk = ((b & c) | (b & d) | (c & d)) + sha_pkg::SHA1_K[2];
                end else begin
                    fk = (b ^ c ^ d) + sha_pkg::SHA1_K[3];
                end
                t1 = ror32(a, 27) + fk + e + win[0][31:0];
                st_next[0] = {32'h0, t1};
                st_next[2] = {32'h0, ror32(b, 2)};
                t2 = win[13][31:0] ^ win[8][31:0] ^ win[2][31:0] ^ win[0][31:0];
                w_new = {32'h0, ror32(t2, 31)};
            end
            sha_pkg::ALG_SHA256: begin
                t1 = st[7][31:0] + (ror32(e, 6) ^ ror32(e, 11) ^ ror32(e, 25))
                   + ((e & st[5][31:0]) ^ (~e & st[6][31:0])) + k[31:0] + win[0][31:0];
                t2 = (ror32(a, 2) ^ ror32(a, 13) ^ ror32(a, 22)) + ((a & b) ^ (a & c) ^ (b & c));
                st_next[0] = {32'h0, t1 + t2};
                st_next[4] = {32'h0, d + t1};
                w_new = {32'h0, (ror32(win[14][31:0], 17) ^ ror32(win[14][31:0], 19) ^ (win[14][31:0] >> 10))
                      + win[9][31:0] + win[0][31:0]
                      + (ror32(win[1][31:0], 7) ^ ror32(win[1][31:0], 18) ^ (win[1][31:0] >> 3))};
            end
            default: begin
                u1 = st[7] + (ror64(st[4], 14) ^ ror64(st[4], 18) ^ ror64(st[4], 41))
                   + ((st[4] & st[5]) ^ (~st[4] & st[6])) + k + win[0];
                u2 = (ror64(st[0], 28) ^ ror64(st[0], 34) ^ ror64(st[0], 39))
                   + ((st[0] & st[1]) ^ (st[0] & st[2]) ^ (st[1] & st[2]));
                st_next[0] = u1 + u2;
                st_next[4] = st[3] + u1;
                w_new = (ror64(win[14], 19) ^ ror64(win[14], 61) ^ (win[14] >> 6)) + win[9] + win[0]
                      + (ror64(win[1], 1) ^ ror64(win[1], 8) ^ (win[1] >> 7));
            end
        endcase
    end
endmodule

//--- tb/sha_hash_accelerator_tb_top.sv
// self-checking bench of the hash accelerator over its avalon slave
`timescale 1ns/1ps
module sha_hash_accelerator_tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] v;
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    int          t0;
    localparam logic [31:0] DG [4][8] = '{
        '{32'ha9993e36, 32'h4706816a, 32'hba3e2571, 32'h7850c26c, 32'h9cd0d89d, 0, 0, 0},
        '{32'hba7816bf, 32'h8f01cfea, 32'h414140de, 32'h5dae2223,
          32'hb00361a3, 32'h96177a9c, 32'hb410ff61, 32'hf20015ad},
        '{32'hcb00753f, 32'h45a35e8b, 0, 0, 0, 0, 0, 0},
        '{32'hddaf35a1, 32'h93617aba, 0, 0, 0, 0, 0, 0}};
    localparam logic [31:0] DG2 [8] = '{32'h248d6a61, 32'hd20638b8, 32'he5c02693, 32'h0c3e6039,
                                        32'ha33ce459, 32'h64ff2167, 32'hf6ecedd4, 32'h19db06c1};
    localparam int ND [4] = '{5, 8, 2, 2};
    localparam int PAST [4] = '{5, 8, 12, 16};
    localparam logic [7:0] RA [4] = '{8'h00, 8'h9c, 8'h80, 8'hc0};
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    sha_hash_accelerator uut (
        .clk             (clk),
        .nrst            (nrst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (4'hf),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            report_and_stop;
        end
    endtask
    task poll(input int a, input int lo, input int hi);
        t0 = cyc;
        do
            xfer(1'b0, 8'h8c + 8'(16 * a), 32'h0);
        while (v[0] !== 1'b0 && cyc - t0 < 400);
        chk("busy_time", 32'(cyc - t0 >= lo && cyc - t0 <= hi + 4), 32'h1);
        if (v[0] !== 1'b0)
            report_and_stop;
    endtask
    // hashes the padded three-letter message with one algorithm
    task run(input int a);
        int last;
        last = (a < 2) ? 15 : 31;
        for (int i = 0; i <= last; i++)
            xfer(1'b1, 8'(4 * i), i == 0 ? 32'h61626380 : i == last ? 32'h18 : 32'h0);
        xfer(1'b1, 8'h80 + 8'(16 * a), 32'h1);
        if (a == 1) begin
            xfer(1'b1, 8'h3c, 32'hffffffff);
            xfer(1'b1, 8'hb0, 32'h1);
            xfer(1'b0, 8'hbc, 32'h0);
            chk("other_busy", v, 32'h0);
        end
        poll(a, 60, 100);
        xfer(1'b1, 8'h88 + 8'(16 * a), 32'h1);
        poll(a, 8, 20);
        for (int i = 0; i < ND[a]; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("digest", v, DG[a][i]);
        end
        xfer(1'b0, 8'(4 * PAST[a]), 32'h0);
        chk("past_digest", v, 32'h0);
        xfer(1'b0, 8'(4 * last), 32'h0);
        chk("kept_word", v, 32'h18);
    endtask
    // two-block message: the second block continues through the next-block trigger
    task run_two;
        logic [31:0] d;
        for (int i = 0; i < 16; i++) begin
            d = i < 14 ? 32'h61626364 + 32'h01010101 * 32'(i) : 32'h0;
            xfer(1'b1, 8'(4 * i), i == 14 ? 32'h80000000 : d);
        end
        xfer(1'b1, 8'h90, 32'h1);
        poll(1, 60, 100);
        for (int i = 0; i < 16; i++)
            xfer(1'b1, 8'(4 * i), i == 15 ? 32'h1c0 : 32'h0);
        xfer(1'b1, 8'h94, 32'h1);
        poll(1, 60, 100);
        xfer(1'b1, 8'h98, 32'h1);
        poll(1, 8, 20);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("chained_digest", v, DG2[i]);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, RA[i], 32'h0);
            chk("reset_read", v, 32'h0);
        end
        xfer(1'b1, 8'h7c, 32'ha5a5c3c3);
        xfer(1'b0, 8'h7c, 32'h0);
        chk("text_rw", v, 32'ha5a5c3c3);
        for (int a = 0; a < 4; a++)
            run(a);
        run_two;
        report_and_stop;
    end
endmodule
